/* File: bench/art_checker_asserts.sv */
/*
  Port checker for the PWM auto-reload timer.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module art_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic halt_i,
  input wire logic [3:0] pwm_output_pin,
  input wire logic [3:0] pwm_output_pin_oe,
  input wire logic overflow_irq_o,
  input wire logic [1:0] capture_irq_o,
  input wire logic [1:0] wakeup_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // Bus answer shape
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_dat_hi; wb_dat_o[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
  ////////////////////////////////////////////////////////////////
  // Pins and requests
  property p_oe_write;
    $changed(pwm_output_pin_oe) |-> $past(wb_ack_o && wb_we_i) || $past(rst_i);
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("drive enable moved alone");
  property p_wake_halt; |wakeup_o |-> $past(halt_i); endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("wake outside halt");
  property p_ovf_fall; $fell(overflow_irq_o) |-> $past(wb_ack_o) || $past(rst_i); endproperty
  a_ovf_fall: assert property (p_ovf_fall) else $error("overflow request dropped");
  property p_cap_fall;
    $fell(capture_irq_o[0]) || $fell(capture_irq_o[1]) |-> $past(wb_ack_o) || $past(rst_i);
  endproperty
  a_cap_fall: assert property (p_cap_fall) else $error("capture request dropped");
  property p_halt_hold; (halt_i && !wb_cyc_i) [*3] |-> $stable(pwm_output_pin); endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("pwm moved in halt");
  c_ovf: cover property (overflow_irq_o);
  c_wake: cover property (|wakeup_o);
  c_cap: cover property ($fell(capture_irq_o[0]));
endmodule : art_checker
`default_nettype wire

/* File: bench/testbench.sv */
/*
  Self-checking bench for the PWM auto-reload timer.
  Assumes the checker file is compiled before this one.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, external_clock_input = 1'b0, halt_i = 1'b0, overflow_irq_o;
  logic [1:0] capture_input_pin = 2'h0, capture_irq_o, wakeup_o;
  logic [3:0] pwm_output_pin, pwm_output_pin_oe;
  int n_fail = 0, n_tests = 0, n_cyc = 0;
  pwm_auto_reload_timer pwm_auto_reload_timer_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_clock_input(external_clock_input), .capture_input_pin(capture_input_pin),
    .halt_i(halt_i), .pwm_output_pin(pwm_output_pin), .pwm_output_pin_oe(pwm_output_pin_oe),
    .overflow_irq_o(overflow_irq_o), .capture_irq_o(capture_irq_o), .wakeup_o(wakeup_o));
  always #5 clk_i = ~clk_i;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // Cycle counter and hang limit
  always @(posedge clk_i) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One classic cycle; entered just after a rising edge
  task automatic wb(input logic we, input logic [7:0] a, input int d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, 8'(d)};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input int d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [7:0] regs[9] = '{art_pkg::off_csr, art_pkg::off_car, art_pkg::off_arr,
      art_pkg::off_pwm_output_control, art_pkg::off_dcr0, art_pkg::off_iccsr, art_pkg::off_icr1,
      art_pkg::off_icr2, 8'h3c};
    int a, v, d, p, c, t0, ch, e, dv;
    void'($urandom(48));
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 0, q);
      chk("reset_value", q, 32'h0);
    end
    a = 224 + ($urandom % 17);
    v = $urandom % 256;
    wr(art_pkg::off_arr, a);
    wr(art_pkg::off_car, v);
    tick(5);
    wb(1'b0, art_pkg::off_car, 0, q);
    chk("held_count", q, 32'(v));
    wr(art_pkg::off_csr, 8'h04);
    wb(1'b0, art_pkg::off_car, 0, q);
    chk("forced_load", q, 32'(a));
    // Overflow period for three divider settings
    for (dv = 0; dv < 3; dv++) begin
      wr(art_pkg::off_csr, 8'h0e | 8'(dv << 4));
      while (overflow_irq_o !== 1'b1) @(posedge clk_i);
      t0 = n_cyc;
      wb(1'b0, art_pkg::off_csr, 0, q);
      chk("ovf_flag", q & 32'h5, 32'h1);
      while (overflow_irq_o !== 1'b1) @(posedge clk_i);
      chk("period", 32'(n_cyc - t0), 32'((256 - a) << dv));
      wb(1'b0, art_pkg::off_csr, 0, q);
    end
    // Duty and polarity on a random channel
    wr(art_pkg::off_csr, 8'h08);
    p = 256 - a;
    ch = $urandom % 4;
    d = a + 1 + ($urandom % (254 - a));
    wr(art_pkg::off_dcr0 + 8'(4 * ch), d);
    for (e = 0; e < 3; e++) begin
      if (e == 2) wr(art_pkg::off_dcr0 + 8'(4 * ch), a);
      wr(art_pkg::off_pwm_output_control, 8'(1 << (ch + 4)) | 8'((e > 0) << ch));
      chk("drive_en", 32'(pwm_output_pin_oe), 32'(1 << ch));
      tick(2 * p);
      c = 0;
      repeat (p) begin
        @(posedge clk_i);
        if (pwm_output_pin[ch] === 1'b1) c++;
      end
      chk("pwm_high", 32'(c), 32'(e == 2 ? p : e ? p - (d - a + 1) : d - a + 1));
    end
    // Event counting on the external input; counter stopped after
    wr(art_pkg::off_csr, 8'h00);
    wb(1'b0, art_pkg::off_csr, 0, q);
    wr(art_pkg::off_csr, 8'h8e);
    for (e = 1; e <= 256 - a; e++) begin
      if (e == 256 - a) chk("early_ovf", 32'(overflow_irq_o), 32'h0);
      external_clock_input <= 1'b1;
      tick(4);
      external_clock_input <= 1'b0;
      tick(4);
    end
    tick(4);
    chk("event_ovf", 32'(overflow_irq_o), 32'h1);
    wr(art_pkg::off_csr, 8'h00);
    // Capture on held counter, both edges, both channels
    for (ch = 0; ch < 2; ch++) begin
      for (e = 0; e < 2; e++) begin
        v = $urandom % 256;
        wr(art_pkg::off_car, v);
        wr(art_pkg::off_iccsr, 8'((e << (4 + ch)) | (1 << (2 + ch))));
        repeat (2) begin
          capture_input_pin[ch] <= ~e[0];
          tick(6);
          capture_input_pin[ch] <= e[0];
          tick(6);
          chk("cap_irq", 32'(capture_irq_o[ch]), 32'h1);
          wr(art_pkg::off_car, v ^ 8'hff);
        end
        wb(1'b0, ch ? art_pkg::off_icr2 : art_pkg::off_icr1, 0, q);
        chk("cap_value", q, 32'(v));
        tick(2);
        chk("cap_clear", 32'(capture_irq_o[ch]), 32'h0);
      end
    end
    // Halt: wake pulse but no capture
    wr(art_pkg::off_iccsr, 8'h14);
    capture_input_pin[0] <= 1'b0;
    tick(6);
    halt_i <= 1'b1;
    tick(3);
    capture_input_pin[0] <= 1'b1;
    c = 0;
    repeat (8) begin
      @(posedge clk_i);
      if (wakeup_o[0] === 1'b1) c++;
    end
    chk("wake", 32'(c), 32'h1);
    halt_i <= 1'b0;
    tick(1);
    wb(1'b0, art_pkg::off_iccsr, 0, q);
    chk("halt_no_cap", q & 32'h3, 32'h0);
    end_sim();
  end
endmodule : testbench
bind pwm_auto_reload_timer art_checker art_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .halt_i(halt_i), .pwm_output_pin(pwm_output_pin),
  .pwm_output_pin_oe(pwm_output_pin_oe), .overflow_irq_o(overflow_irq_o),
  .capture_irq_o(capture_irq_o), .wakeup_o(wakeup_o));
`default_nettype wire

/* File: design/art_pkg.sv */
/*
  Constants for the PWM auto-reload timer: register offsets, field
  positions, reset values and timing figures.
  Assumes a classic Wishbone slave with 32-bit data, 8-bit registers.
*/
package art_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] off_csr = 8'h00; // Timer control/status
  localparam logic [7:0] off_car = 8'h04; // Counter access
  localparam logic [7:0] off_arr = 8'h08; // Auto-reload value
  localparam logic [7:0] off_pwm_output_control = 8'h0c; // PWM output control
  localparam logic [7:0] off_dcr0 = 8'h10; // Duty cycle 0..3 at 10,14,18,1c
  localparam logic [7:0] off_iccsr = 8'h20; // Capture control/status
  localparam logic [7:0] off_icr1 = 8'h24; // Capture value 1
  localparam logic [7:0] off_icr2 = 8'h28; // Capture value 2
  localparam logic [7:0] off_halt = 8'h2c; // Halt mode status, read only
  // Control/status field positions
  localparam int csr_ext_bit = 7; // External clock select
  localparam int csr_div_lsb = 4; // Counter clock divider [6:4]
  localparam int csr_en_bit = 3; // Counter enable
  localparam int csr_frl_bit = 2; // Forced reload
  localparam int csr_oie_bit = 1; // Overflow interrupt enable
  localparam int csr_ovf_bit = 0; // Overflow flag
  // Capture control/status field positions
  localparam int icc_edge_lsb = 4; // Edge select [5:4]
  localparam int icc_cie_lsb = 2; // Capture int enable [3:2]
  localparam int icc_cf_lsb = 0; // Capture flag [1:0]
  // Reset values
  localparam logic [7:0] reg_reset = 8'h00; // All registers
  localparam logic [6:0] presc_reset = 7'h00; // Prescaler
  // Counter top value before overflow
  localparam logic [7:0] count_top = 8'hff;
endpackage : art_pkg

/* File: design/pwm_auto_reload_timer.sv */
/*
  PWM auto-reload timer: 8-bit counter with 7-bit prescaler, four PWM
  channels sharing one period, overflow time base, event counter and two
  input capture channels with halt wake-up. Classic Wishbone slave.
  Assumes pins synchronous to clk_i; chip halt state given on halt_i.
*/
// Function
// - 8-bit counter steps on prescaler output
// - Overflow reloads counter, prescaler untouched
// - Software reads and writes live counter
// - 7-bit prescaler, divide by two to field
// - Prescaler input CPU or external clock
// - Enable clear freezes prescaler and counter
// - Reset clears counter, prescaler, selects CPU
// - Counter write clears prescaler, forced reload only with enable set
// - Hidden compares load from duty at overflow
// - Output enable drives channel pin
// - Shared period is 256 minus reload
// - Overflow sets polarity level, compare restores
// - Waveform only when compare exceeds reload
// - PWM generation stops during halt
// - Overflow sets flag, optional interrupt
// - Event mode flags after 256 minus reload
// - Capture edge latches counter, sets flag
// - Edge select picks rising or falling
// - Capture blocked until value read
// - Capture input synchronised, two edges
// - Halt: no capture, edge still wakes
// - Reading control/status clears overflow flag
// - Reading capture value clears its flag
// - Forced reload write-only, reads zero
// - Polarity sets level, change acts immediately
`timescale 1ns/1ps
`default_nettype none

module pwm_auto_reload_timer (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic external_clock_input, // External count clock
  input wire logic [1:0] capture_input_pin, // Capture pins
  input wire logic halt_i, // Chip in halt mode
  output logic [3:0] pwm_output_pin, // PWM pin levels
  output logic [3:0] pwm_output_pin_oe, // PWM pin drive enables
  output logic overflow_irq_o, // Overflow interrupt request
  output logic [1:0] capture_irq_o, // Capture interrupt requests
  output logic [1:0] wakeup_o // Halt wake-up pulses
);

  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] timer_control_status; // Control bits, flag at bit 0
  logic [7:0] counter_access_reg; // Live counter
  logic [7:0] auto_reload_value; // Reload value
  logic [7:0] pwm_output_control; // Enables [7:4], polarity [3:0]
  logic [7:0] duty_cycle_reg [4]; // Duty cycle per channel
  logic [7:0] hidden_compare_value [4]; // Double-buffered compares
  logic [5:0] capture_ctrl_reg; // Edge select and int enables
  logic [1:0] capture_flag; // Capture flags
  logic [7:0] capture_value_reg [2]; // Captured counter values
  logic [6:0] presc_reg; // Prescaler
  logic [3:0] pwm_raw_reg; // Waveform before polarity
  logic ext_prev_reg; // External clock last level
  logic [1:0] cap_s1_reg; // Capture sync stage 1
  logic [1:0] cap_s2_reg; // Capture sync stage 2
  logic [1:0] cap_s3_reg; // Capture sync previous level
  logic [1:0] pin_prev_reg; // Raw pin last level for halt
  logic [7:0] presc_next; // Next prescaler
  logic [7:0] presc_cnt_next; // Wide prescaler sum

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  logic bus_req; // Request live and not yet answered
  logic wr_stb; // Write taken this cycle
  logic rd_stb; // Read taken this cycle
  logic [7:0] wr_byte; // Low lane write data

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = bus_req && wb_we_i && wb_sel_i[0];
  assign rd_stb = bus_req && !wb_we_i;
  assign wr_byte = wb_dat_i[7:0];

  // Address match helper
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////
  // Clock selection and prescaler
  logic ext_sel; // External clock chosen
  logic cnt_en; // Counter enable
  logic [2:0] div_sel; // Divider tap
  logic in_tick; // One prescaler input event
  logic cnt_tick; // One counter clock event
  logic overflow; // Counter overflow this cycle
  logic car_wr; // Counter access write
  logic frl_wr; // Forced reload write

  assign ext_sel = timer_control_status[art_pkg::csr_ext_bit];
  assign cnt_en = timer_control_status[art_pkg::csr_en_bit];
  assign div_sel = timer_control_status[art_pkg::csr_div_lsb +: 3];
  // CPU clock ticks every cycle, external on a rising edge
  assign in_tick = ext_sel ? (external_clock_input && !ext_prev_reg) : 1'b1;
  assign presc_cnt_next = {1'b0, presc_reg} + 8'h01;
  // Tap n fires when the low n bits roll over
  assign cnt_tick = cnt_en && in_tick &&
                    ((presc_reg & ((7'h01 << div_sel) - 7'h01)) ==
                     ((7'h01 << div_sel) - 7'h01));
  assign overflow = cnt_tick && (counter_access_reg == art_pkg::count_top);
  assign car_wr = wr_stb && hit(wb_adr_i, art_pkg::off_car);
  assign frl_wr = wr_stb && hit(wb_adr_i, art_pkg::off_csr) &&
                  wr_byte[art_pkg::csr_frl_bit];
  assign presc_next = presc_cnt_next;

  // External clock edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= external_clock_input;
    end
  end

  // Prescaler: frozen when disabled, cleared on counter write or on forced reload with enable set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_reg <= art_pkg::presc_reset;
    end else if (car_wr || (frl_wr && wr_byte[art_pkg::csr_en_bit])) begin
      presc_reg <= art_pkg::presc_reset;
    end else if (cnt_en && in_tick) begin
      presc_reg <= presc_next[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_access_reg <= art_pkg::reg_reset;
    end else if (car_wr) begin
      counter_access_reg <= wr_byte;
    end else if (frl_wr) begin
      counter_access_reg <= auto_reload_value;
    end else if (overflow) begin
      counter_access_reg <= auto_reload_value;
    end else if (cnt_tick) begin
      counter_access_reg <= counter_access_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control/status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_status <= art_pkg::reg_reset;
    end else begin
      if (wr_stb && hit(wb_adr_i, art_pkg::off_csr)) begin
        // Forced reload is not stored
        timer_control_status[7:1] <= {wr_byte[7:3], 1'b0, wr_byte[1]};
      end
      if (overflow) begin
        timer_control_status[art_pkg::csr_ovf_bit] <= 1'b1;
      end else if (rd_stb && hit(wb_adr_i, art_pkg::off_csr)) begin
        timer_control_status[art_pkg::csr_ovf_bit] <= 1'b0;
      end
    end
  end

  // Other software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_reload_value <= art_pkg::reg_reset;
      pwm_output_control <= art_pkg::reg_reset;
      capture_ctrl_reg <= 6'h00;
      for (int i = 0; i < 4; i++) begin
        duty_cycle_reg[i] <= art_pkg::reg_reset;
      end
    end else if (wr_stb) begin
      if (hit(wb_adr_i, art_pkg::off_arr)) begin
        auto_reload_value <= wr_byte;
      end else if (hit(wb_adr_i, art_pkg::off_pwm_output_control)) begin
        pwm_output_control <= wr_byte;
      end else if (hit(wb_adr_i, art_pkg::off_iccsr)) begin
        capture_ctrl_reg <= wr_byte[5:0];
      end else if (wb_adr_i[7:4] == art_pkg::off_dcr0[7:4] && wb_adr_i[1:0] == 2'h0) begin
        duty_cycle_reg[wb_adr_i[3:2]] <= wr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // PWM compare and output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_raw_reg <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        hidden_compare_value[i] <= art_pkg::reg_reset;
      end
    end else if (!halt_i) begin
      for (int i = 0; i < 4; i++) begin
        if (overflow) begin
          hidden_compare_value[i] <= duty_cycle_reg[i];
          // Active part starts at overflow only if compare above reload
          pwm_raw_reg[i] <= (duty_cycle_reg[i] > auto_reload_value);
        end else if (cnt_tick && counter_access_reg == hidden_compare_value[i]) begin
          pwm_raw_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Polarity applied at output flop; a polarity write flips next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_output_pin <= 4'h0;
      pwm_output_pin_oe <= 4'h0;
    end else begin
      pwm_output_pin <= pwm_raw_reg ^ pwm_output_control[3:0];
      pwm_output_pin_oe <= pwm_output_control[7:4];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Input capture
  logic [1:0] edge_sel; // 1 rising, 0 falling
  logic [1:0] cap_ie; // Capture interrupt enables
  logic [1:0] cap_edge; // Synchronised active edge
  logic [1:0] pin_edge; // Raw active edge for halt wake-up

  assign edge_sel = capture_ctrl_reg[art_pkg::icc_edge_lsb +: 2];
  assign cap_ie = capture_ctrl_reg[art_pkg::icc_cie_lsb +: 2];
  assign cap_edge = (edge_sel & cap_s2_reg & ~cap_s3_reg) |
                    (~edge_sel & ~cap_s2_reg & cap_s3_reg);
  assign pin_edge = (edge_sel & capture_input_pin & ~pin_prev_reg) |
                    (~edge_sel & ~capture_input_pin & pin_prev_reg);

  // Two-stage synchroniser and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_s1_reg <= 2'h0;
      cap_s2_reg <= 2'h0;
      cap_s3_reg <= 2'h0;
      pin_prev_reg <= 2'h0;
    end else begin
      cap_s1_reg <= capture_input_pin;
      cap_s2_reg <= cap_s1_reg;
      cap_s3_reg <= cap_s2_reg;
      pin_prev_reg <= capture_input_pin;
    end
  end

  // Capture latch, flags and read-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_flag <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        capture_value_reg[i] <= art_pkg::reg_reset;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_edge[i] && !capture_flag[i] && !halt_i) begin
          capture_value_reg[i] <= counter_access_reg;
          capture_flag[i] <= 1'b1;
        end else if (rd_stb && hit(wb_adr_i, i == 0 ? art_pkg::off_icr1
                                                    : art_pkg::off_icr2)) begin
          capture_flag[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt and wake-up outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_irq_o <= 1'b0;
      capture_irq_o <= 2'h0;
      wakeup_o <= 2'h0;
    end else begin
      overflow_irq_o <= timer_control_status[art_pkg::csr_ovf_bit] &&
                        timer_control_status[art_pkg::csr_oie_bit];
      capture_irq_o <= capture_flag & cap_ie;
      wakeup_o <= halt_i ? (pin_edge & cap_ie) : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, ack one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (rd_stb) begin
        if (hit(wb_adr_i, art_pkg::off_csr)) begin
          // Forced reload bit is stored as zero
          wb_dat_o[7:0] <= timer_control_status;
        end else if (hit(wb_adr_i, art_pkg::off_car)) begin
          wb_dat_o[7:0] <= counter_access_reg;
        end else if (hit(wb_adr_i, art_pkg::off_arr)) begin
          wb_dat_o[7:0] <= auto_reload_value;
        end else if (hit(wb_adr_i, art_pkg::off_pwm_output_control)) begin
          wb_dat_o[7:0] <= pwm_output_control;
        end else if (wb_adr_i[7:4] == art_pkg::off_dcr0[7:4] && wb_adr_i[1:0] == 2'h0) begin
          wb_dat_o[7:0] <= duty_cycle_reg[wb_adr_i[3:2]];
        end else if (hit(wb_adr_i, art_pkg::off_iccsr)) begin
          wb_dat_o[7:0] <= {2'h0, capture_ctrl_reg[5:2], capture_flag};
        end else if (hit(wb_adr_i, art_pkg::off_icr1)) begin
          wb_dat_o[7:0] <= capture_value_reg[0];
        end else if (hit(wb_adr_i, art_pkg::off_icr2)) begin
          wb_dat_o[7:0] <= capture_value_reg[1];
        end else if (hit(wb_adr_i, art_pkg::off_halt)) begin
          wb_dat_o[7:0] <= {7'h00, halt_i};
        end
      end
    end
  end

endmodule : pwm_auto_reload_timer

`default_nettype wire
